// ---- pkg/pfs_defs.vh ----
// register offsets, field positions and reset values of the pin function bank
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// word offsets on the register bus
`define PFS_ADDR_W          2
`define PFS_OFS_ADDR_EN     2'h0
`define PFS_OFS_TCLK_STRB   2'h1
`define PFS_OFS_TPIN_MUX    2'h2

// byte lane that carries every register on the bus
`define PFS_BYTE_MSB        7
`define PFS_BYTE_LSB        0
`define PFS_WR_LANE         0

// upper address enable register
`define PFS_AE_A23_BIT      7
`define PFS_AE_A22_BIT      6
`define PFS_AE_A21_BIT      5
`define PFS_AE_RSVD_ONES    8'h1f
`define PFS_AE_RESET        8'h1f

// timer clock and strobe select register
`define PFS_TC_RSVD7_BIT    7
`define PFS_TC_STRB_BIT     6
`define PFS_TC_RSVD5_BIT    5
`define PFS_TC_RO4_BIT      4
`define PFS_TC_TCLK_BIT     3
`define PFS_TC_RESET        8'he0
`define PFS_TC_RSVD_ONES    8'ha0

// timer pin multiplex register
`define PFS_TM_CH5A_BIT     7
`define PFS_TM_CH4A_BIT     6
`define PFS_TM_CH3A_BIT     5
`define PFS_TM_CH3C_BIT     4
`define PFS_TM_RESET        8'h00

`endif

// ---- rtl/pfs_port_function_select_bank.v ----
// pin function select bank: three config registers on an avalon-mm slave
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defs.vh"

module pfs_port_function_select_bank
(
    // clock, reset, enable
    input  wire                      clk_i,
    input  wire                      rst_n_i,
    input  wire                      clk_en_i,
    // avalon-mm slave
    input  wire [`PFS_ADDR_W-1:0]    avs_address_i,
    input  wire                      avs_read_i,
    input  wire                      avs_write_i,
    input  wire [31:0]               avs_writedata_i,
    input  wire [3:0]                avs_byteenable_i,
    output reg  [31:0]               avs_readdata_o,
    output wire                      avs_waitrequest_o,
    // operating mode
    input  wire                      ext_extended_mode_i,
    // address line pin enables
    output wire                      addr_bit23_out_en_o,
    output wire                      addr_bit22_out_en_o,
    output wire                      addr_bit21_out_en_o,
    // write strobe pin role
    output wire                      low_half_write_strobe_en_o,
    // timer external clock pin group
    output wire                      timer_ext_clock_pin_sel_o,
    // timer capture split selects
    output wire                      chan5a_capture_split_o,
    output wire                      chan4a_capture_split_o,
    output wire                      chan3a_capture_split_o,
    output wire                      chan3c_capture_split_o
);

    // field widths and positions inside the stored copies
    localparam ADDR_EN_W = `PFS_AE_A23_BIT - `PFS_AE_A21_BIT + 1;
    localparam A23_IDX   = `PFS_AE_A23_BIT - `PFS_AE_A21_BIT;
    localparam A22_IDX   = `PFS_AE_A22_BIT - `PFS_AE_A21_BIT;
    localparam A21_IDX   = `PFS_AE_A21_BIT - `PFS_AE_A21_BIT;
    localparam BYTE_W    = `PFS_BYTE_MSB - `PFS_BYTE_LSB + 1;
    localparam DATA_W    = 32;

    // whole-register reset images, cut to the stored fields on purpose
    localparam [7:0] AE_RESET_IMAGE = `PFS_AE_RESET;
    localparam [7:0] TC_RESET_IMAGE = `PFS_TC_RESET;
    localparam [7:0] TM_RESET_IMAGE = `PFS_TM_RESET;
    localparam [ADDR_EN_W-1:0] ADDR_EN_RESET =
        AE_RESET_IMAGE[`PFS_AE_A23_BIT:`PFS_AE_A21_BIT];
    localparam [0:0] STROBE_RESET = TC_RESET_IMAGE[`PFS_TC_STRB_BIT];
    localparam [0:0] TCLK_RESET   = TC_RESET_IMAGE[`PFS_TC_TCLK_BIT];

    // stored writable bits only; reserved bits are constants
    reg  [ADDR_EN_W-1:0] addr_en;
    reg                  strobe_sel;
    reg                  tclk_sel;
    reg  [7:0]           tpin_mux;
    reg                  ack;

    // next values from the combinational write decode
    reg  [ADDR_EN_W-1:0] next_addr_en;
    reg                  next_strobe_sel;
    reg                  next_tclk_sel;
    reg  [7:0]           next_tpin_mux;
    reg                  next_ack;
    reg  [DATA_W-1:0]    next_readdata;

    // bus qualifiers
    wire                 req;
    wire                 ack_live;
    wire                 wr_commit;
    wire                 rd_capture;
    wire [BYTE_W-1:0]    wr_byte;
    wire                 hit_ae;
    wire                 hit_tc;
    wire                 hit_tm;

    // readback images with reserved bits forced
    wire [7:0]           ae_image;
    wire [7:0]           tc_image;
    wire [7:0]           tm_image;

    // true when the word index on the bus names the given register
    function pfs_hit;
        input [`PFS_ADDR_W-1:0] ofs;
        input [`PFS_ADDR_W-1:0] target;
        begin
            pfs_hit = (ofs == target);
        end
    endfunction

    // one stored bit moved to its place in the readback byte
    function [7:0] pfs_place;
        input         bit_val;
        input integer pos;
        begin
            pfs_place = {7'h00, bit_val} << pos;
        end
    endfunction

    // readback image picked by word index; unmapped words read zero
    function [7:0] pfs_image;
        input [`PFS_ADDR_W-1:0] ofs;
        begin
            case (ofs)
                `PFS_OFS_ADDR_EN:
                    pfs_image = ae_image;
                `PFS_OFS_TCLK_STRB:
                    pfs_image = tc_image;
                `PFS_OFS_TPIN_MUX:
                    pfs_image = tm_image;
                default:
                    pfs_image = 8'h00;
            endcase
        end
    endfunction

    // request decode shared by the handshake and the write path
    assign req      = avs_read_i | avs_write_i;
    assign ack_live = ack & clk_en_i;
    assign wr_byte  = avs_writedata_i[`PFS_BYTE_MSB:`PFS_BYTE_LSB];

    // a write lands only on the edge the master sees waitrequest low;
    // a cleared lane 0 enable means no register byte is written
    assign wr_commit  = avs_write_i & ack_live &
                        avs_byteenable_i[`PFS_WR_LANE];

    // read data is caught one edge before the master samples it
    assign rd_capture = req & ~ack & clk_en_i;

    // word decode; the fourth index matches none and is dropped
    assign hit_ae     = pfs_hit(avs_address_i, `PFS_OFS_ADDR_EN);
    assign hit_tc     = pfs_hit(avs_address_i, `PFS_OFS_TCLK_STRB);
    assign hit_tm     = pfs_hit(avs_address_i, `PFS_OFS_TPIN_MUX);

    // one wait state; a frozen enable keeps the master waiting, so a
    // stalled clock never ends a transfer whose write did not land
    assign avs_waitrequest_o = req & ~ack_live;

    // acknowledge rises for one cycle per request
    always @*
    begin
        next_ack = req & ~ack;
    end

    // acknowledge flop; frozen with the rest of the state
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack <= 1'b0;
        end
        else if (clk_en_i)
        begin
            ack <= next_ack;
        end
    end

    // address enable image: stored bits high, reserved ones forced
    assign ae_image = pfs_place(addr_en[A23_IDX], `PFS_AE_A23_BIT) |
                      pfs_place(addr_en[A22_IDX], `PFS_AE_A22_BIT) |
                      pfs_place(addr_en[A21_IDX], `PFS_AE_A21_BIT) |
                      `PFS_AE_RSVD_ONES;

    // timer clock image: bits 7 and 5 read one, bit 4 and 2..0 zero;
    // nothing stores them, so a careless write cannot flip them
    assign tc_image = pfs_place(strobe_sel, `PFS_TC_STRB_BIT) |
                      pfs_place(tclk_sel,   `PFS_TC_TCLK_BIT) |
                      `PFS_TC_RSVD_ONES;

    // timer pin image: every bit stored as written, the low four
    // belong to channels routed elsewhere but keep their value
    assign tm_image = tpin_mux;

    // address enable next value; reserved write bits are not kept
    always @*
    begin
        next_addr_en = addr_en;
        if (wr_commit && hit_ae)
        begin
            next_addr_en = wr_byte[`PFS_AE_A23_BIT:`PFS_AE_A21_BIT];
        end
    end

    // strobe and timer clock next values; bit 4 has no storage, so a
    // write can never move it
    always @*
    begin
        next_strobe_sel = strobe_sel;
        next_tclk_sel   = tclk_sel;
        if (wr_commit && hit_tc)
        begin
            next_strobe_sel = wr_byte[`PFS_TC_STRB_BIT];
            next_tclk_sel   = wr_byte[`PFS_TC_TCLK_BIT];
        end
    end

    // timer pin multiplex next value
    always @*
    begin
        next_tpin_mux = tpin_mux;
        if (wr_commit && hit_tm)
        begin
            next_tpin_mux = wr_byte;
        end
    end

    // read data next value, the image of the addressed word with the
    // upper lanes held at zero
    always @*
    begin
        next_readdata = {{(DATA_W-BYTE_W){1'b0}},
                         pfs_image(avs_address_i)};
    end

    // address enable register; all three lines start off the pins
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_en <= ADDR_EN_RESET;
        end
        else if (clk_en_i)
        begin
            addr_en <= next_addr_en;
        end
    end

    // strobe role and timer clock group; strobe starts enabled so the
    // pin comes up as the write strobe in extended mode
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strobe_sel <= STROBE_RESET;
            tclk_sel   <= TCLK_RESET;
        end
        else if (clk_en_i)
        begin
            strobe_sel <= next_strobe_sel;
            tclk_sel   <= next_tclk_sel;
        end
    end

    // timer pin multiplex register; every channel starts shared
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tpin_mux <= TM_RESET_IMAGE;
        end
        else if (clk_en_i)
        begin
            tpin_mux <= next_tpin_mux;
        end
    end

    // read data register; caught one edge before the taking edge and left standing
    // until the next request, so a slow master still sees it
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_readdata_o <= {DATA_W{1'b0}};
        end
        else if (rd_capture)
        begin
            avs_readdata_o <= next_readdata;
        end
    end

    // pin routing straight from registers, live the edge after a write;
    // no extra flop, so the route follows the register at once
    assign addr_bit23_out_en_o = addr_en[A23_IDX];
    assign addr_bit22_out_en_o = addr_en[A22_IDX];
    assign addr_bit21_out_en_o = addr_en[A21_IDX];

    // outside extended mode the pin stays a plain port whatever the bit;
    // the register still reads back what software wrote
    assign low_half_write_strobe_en_o = strobe_sel &
                                        ext_extended_mode_i;

    // timer clock group: low picks the port 3 set, high the port 1 set
    assign timer_ext_clock_pin_sel_o  = tclk_sel;

    // capture split selects; the compare output never moves
    assign chan5a_capture_split_o = tpin_mux[`PFS_TM_CH5A_BIT];
    assign chan4a_capture_split_o = tpin_mux[`PFS_TM_CH4A_BIT];
    assign chan3a_capture_split_o = tpin_mux[`PFS_TM_CH3A_BIT];
    assign chan3c_capture_split_o = tpin_mux[`PFS_TM_CH3C_BIT];

endmodule // pfs_port_function_select_bank
`default_nettype wire

// ---- test/pfs_monitor.sv ----
// assertion checker on the pin function select bank ports
`timescale 1ns/1ps
`default_nettype none
module pfs_monitor
(
    // bus, mode and watched pin outputs
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        clk_en_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [1:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        ext_extended_mode_i,
    input wire logic        addr_bit23_out_en_o,
    input wire logic        low_half_write_strobe_en_o
);
    // completed transfers; a write counts only with byte lane 0 set
    wire       rd = avs_read_i & ~avs_waitrequest_o;
    wire       wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    wire [7:0] q  = avs_readdata_o[7:0];
    wire [7:0] d  = avs_writedata_i[7:0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    strb_gate_a: assert property (low_half_write_strobe_en_o
        |-> ext_extended_mode_i) else $error("strobe outside mode");
    one_wait_a: assert property (avs_waitrequest_o && clk_en_i
        |=> !avs_waitrequest_o || !clk_en_i) else $error("wait too long");
    idle_wait_a: assert property (!avs_read_i && !avs_write_i
        |-> !avs_waitrequest_o) else $error("wait when idle");
    ae_read_a: assert property (rd && avs_address_i == 2'h0
        |-> q[4:0] == 5'h1f) else $error("ones misread");
    tc_read_a: assert property (rd && avs_address_i == 2'h1
        |-> {q[7], q[5:4], q[2:0]} == 6'h30) else $error("timer misread");
    gap_read_a: assert property (rd && avs_address_i == 2'h3
        |-> q == 8'h00) else $error("gap not zero");
    ae_write_a: assert property (wr && avs_address_i == 2'h0
        |=> addr_bit23_out_en_o == $past(d[7])) else $error("a23 lost");
    strb_write_a: assert property (wr && avs_address_i == 2'h1
        |=> low_half_write_strobe_en_o ==
            ($past(d[6]) && ext_extended_mode_i)) else $error("strobe lost");
endmodule // pfs_monitor
bind pfs_port_function_select_bank pfs_monitor i_pfs_monitor (.*);
`default_nettype wire

// ---- test/testbench.sv ----
// random register traffic and pin checks for the pin function select bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 0, rst_n_i = 0, clk_en_i = 1, avs_read_i = 0;
    logic        avs_write_i = 0, ext_extended_mode_i = 0;
    logic [1:0]  avs_address_i = 0, a;
    logic [3:0]  avs_byteenable_i = 4'h1;
    logic [31:0] avs_writedata_i = 0, q;
    logic [7:0]  d, r [3] = '{8'h00, 8'h40, 8'h00};
    wire  [31:0] avs_readdata_o;
    wire         avs_waitrequest_o, addr_bit23_out_en_o, addr_bit22_out_en_o,
        addr_bit21_out_en_o, low_half_write_strobe_en_o, chan3c_capture_split_o,
        timer_ext_clock_pin_sel_o, chan5a_capture_split_o,
        chan4a_capture_split_o, chan3a_capture_split_o;
    wire  [8:0]  pins = {addr_bit23_out_en_o, addr_bit22_out_en_o,
        addr_bit21_out_en_o, low_half_write_strobe_en_o,
        timer_ext_clock_pin_sel_o, chan5a_capture_split_o,
        chan4a_capture_split_o, chan3a_capture_split_o,
        chan3c_capture_split_o};
    int          miscompares = 0, tests_run = 0, cyc = 0;
    pfs_port_function_select_bank i_pfs_port_function_select_bank (.*);
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (++cyc == 3000) tally_and_finish(1);
    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        miscompares += s !== e;
        if (s !== e) $display("[FAIL] %s exp %h got %h", n, e, s);
    endtask
    task automatic tally_and_finish(input int hang);
        miscompares += hang;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // request held until waitrequest is sampled low at an edge
    task automatic bus(input logic w);
        @(posedge clk_i);
        {avs_write_i, avs_read_i} <= {w, !w};
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        {avs_write_i, avs_read_i} <= 2'b00;
    endtask
    // expected read word and pin levels from the shadow copy
    function automatic logic [31:0] rexp(input logic [1:0] x);
        rexp = x == 0 ? {r[0][7:5], 5'h1f} : x == 2 ? r[2] : x == 3 ? 8'h0
            : {1'b1, r[1][6], 2'b10, r[1][3], 3'h0};
    endfunction
    function automatic logic [31:0] pexp();
        pexp = {r[0][7:5], r[1][6] & ext_extended_mode_i, r[1][3], r[2][7:4]};
    endfunction
    initial
    begin
        void'($urandom(38));
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1;
        // reset reads of every offset, then random write and readback
        for (int i = 0; i < 60; i++)
        begin
            a = 2'(i < 4 ? i : $urandom);
            d = 8'($urandom);
            // reserved bits written as software must
            d = a == 0 ? d | 8'h1f : a == 1 ? d & 8'hf8 | 8'ha0 : d;
            ext_extended_mode_i <= 1'($urandom);
            avs_byteenable_i <= i < 12 ? 4'h1 : 4'($urandom);
            if (i > 3) bus(1);
            if (i > 3 && a < 3 && avs_byteenable_i[0]) r[a] = d;
            #1 chk("pins", pins, pexp());
            chk("split", pins[3:0], r[2][7:4]);
            bus(0);
            chk("read", q, rexp(a));
        end
        tally_and_finish(0);
    end
endmodule // testbench
`default_nettype wire
